/* rtl/pfs_port0_regs.svh */
// Register indices, reset values, fields and select codes of port 0
`ifndef PFS_PORT0_REGS_SVH
`define PFS_PORT0_REGS_SVH

// Register indices; the bus byte address is four times the index
`define PFS_IDX_DATA     16'hF210
`define PFS_IDX_DIR      16'hF211
`define PFS_IDX_CON      16'hF212
`define PFS_IDX_MODE     16'hF214
`define PFS_BADDR(idx)   ({(idx), 2'h0})

// Reset values
`define PFS_RST_DATA     8'h00
`define PFS_RST_DIR      8'h00
`define PFS_RST_CON      16'h0000
`define PFS_RST_MODE     16'h0000

// High select/config bit of pin n sits at n plus this offset
`define PFS_HI_LSB       8

// Pin function select codes (high,low)
`define PFS_CODE_GPIO    2'h0
`define PFS_CODE_RC      2'h1
`define PFS_CODE_ALT2    2'h2
`define PFS_CODE_ALT3    2'h3

// Pins on which the two upper codes are prohibited
`define PFS_ALT2_BAD     6'h38
`define PFS_ALT3_BAD     6'h30

// Bus answer latency in clock cycles after the request first appears
`define PFS_BUS_LAT      1

`endif

/* rtl/pfs_pkg.sv */
// Types shared by the port 0 function select design
package pfs_pkg;

  // Drive/pull configuration code (high,low)
  typedef enum logic [1:0] {
    DRV_HIZ  = 2'h0,
    DRV_PCH  = 2'h1,
    DRV_NCH  = 2'h2,
    DRV_CMOS = 2'h3
  } pfs_drive_e;

  // Bus slave states, one-hot
  typedef enum logic [1:0] {
    BUS_IDLE = 2'h1,
    BUS_ACK  = 2'h2
  } pfs_bus_e;

  // Output source chosen for one pin
  typedef struct packed {
    logic drive;
    logic val;
    logic prohib;
  } pfs_src_s;

endpackage : pfs_pkg

/* rtl/pfs_pad_if.sv */
// Per-pin carrier between the register block and a pad cell
`timescale 1ns/1ps
`default_nettype none
interface pfs_pad_if
  import pfs_pkg::*;
();
  logic       dir;
  pfs_drive_e cfg;
  pfs_src_s   src;
  logic       pin_out;
  logic       pin_oe;
  logic       pull_up;
  logic       pull_down;

  modport ctl (output dir, cfg, src,
               input  pin_out, pin_oe, pull_up, pull_down);
  modport pad (input  dir, cfg, src,
               output pin_out, pin_oe, pull_up, pull_down);
endinterface : pfs_pad_if
`default_nettype wire

/* rtl/pfs_pad_cell.sv */
// One pad cell: direction, drive type, pulls and prohibited-code hold
`timescale 1ns/1ps
`default_nettype none
module pfs_pad_cell
  import pfs_pkg::*;
(
  input  wire logic ref_clk_in,
  input  wire logic rst_in,
  pfs_pad_if.pad    pad
);

  logic out_r, out_nxt;
  logic oe_r, oe_nxt;
  logic pu_r, pu_nxt;
  logic pd_r, pd_nxt;

  // Pad control from direction, drive type and source
  always_comb begin
    out_nxt = 1'h0;
    oe_nxt  = 1'h0;
    pu_nxt  = 1'h0;
    pd_nxt  = 1'h0;
    if (pad.dir) begin
      pu_nxt = (pad.cfg == DRV_NCH);  // see R11
      pd_nxt = (pad.cfg == DRV_PCH);  // see R11
    end else if (pad.src.prohib) begin
      // Data ignored; N-ch and CMOS hold low, others float, see R8
      oe_nxt = (pad.cfg == DRV_NCH) || (pad.cfg == DRV_CMOS);
    end else if (pad.src.drive) begin
      case (pad.cfg)  // see R10
        DRV_PCH: begin
          out_nxt = 1'h1;
          oe_nxt  = pad.src.val;
        end
        DRV_NCH: begin
          oe_nxt  = ~pad.src.val;
        end
        DRV_CMOS: begin
          out_nxt = pad.src.val;  // see R13
          oe_nxt  = 1'h1;
        end
        default: begin
          oe_nxt  = 1'h0;
        end
      endcase
    end
  end

  // Pad outputs registered; reset leaves high-impedance output
  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      out_r <= 1'h0;  // see R12
      oe_r  <= 1'h0;
      pu_r  <= 1'h0;
      pd_r  <= 1'h0;
    end else begin
      out_r <= out_nxt;
      oe_r  <= oe_nxt;
      pu_r  <= pu_nxt;
      pd_r  <= pd_nxt;
    end
  end

  assign pad.pin_out   = out_r;
  assign pad.pin_oe    = oe_r;
  assign pad.pull_up   = pu_r;
  assign pad.pull_down = pd_r;

  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (rst_in);

  property p_input_floats;
    pad.dir |=> !pad.pin_oe;
  endproperty
  a_input_floats: assert property (p_input_floats)  // see R9
    else $error("pad driven in input mode");

  property p_prohib_low;
    !pad.dir && pad.src.prohib && pad.cfg inside {DRV_NCH, DRV_CMOS}
      |=> pad.pin_oe && !pad.pin_out;
  endproperty
  a_prohib_low: assert property (p_prohib_low)  // see R8
    else $error("prohibited code not held low");

  property p_prohib_float;
    !pad.dir && pad.src.prohib && pad.cfg inside {DRV_HIZ, DRV_PCH}
      |=> !pad.pin_oe;
  endproperty
  a_prohib_float: assert property (p_prohib_float)  // see R8
    else $error("prohibited code not floating");

  property p_cmos_follow;
    !pad.dir && !pad.src.prohib && pad.src.drive && pad.cfg == DRV_CMOS
      |=> pad.pin_oe && pad.pin_out == $past(pad.src.val);
  endproperty
  a_cmos_follow: assert property (p_cmos_follow)  // see R13
    else $error("CMOS pin does not follow its source");

  property p_nch_od;
    !pad.dir && !pad.src.prohib && pad.src.drive && pad.cfg == DRV_NCH
      |=> !pad.pin_out && pad.pin_oe == !$past(pad.src.val);
  endproperty
  a_nch_od: assert property (p_nch_od)  // see R10
    else $error("N-channel open drain wrong");

  property p_pulls;
    pad.dir |=> (pad.pull_up == ($past(pad.cfg) == DRV_NCH))
             && (pad.pull_down == ($past(pad.cfg) == DRV_PCH));
  endproperty
  a_pulls: assert property (p_pulls)  // see R11
    else $error("pull selection wrong");

endmodule : pfs_pad_cell
`default_nettype wire

/* rtl/pfs_port0_fsel.sv */
// Port 0 pin function select, direction, drive and data registers
`timescale 1ns/1ps
`default_nettype none
`include "pfs_port0_regs.svh"
// What this block does
// R1: 16-bit select register, reset zero, byte or word writes, low/high bits.
// R2: Pin 0: gpio, RC waveform input, serial data out, UART receive.
// R3: Pin 1: gpio, RC reference capacitor, serial data in, UART transmit.
// R4: Pin 2: gpio, RC sensor pin, serial clock, timer output zero.
// R5: Pin 3: gpio, RC reference resistor, prohibited, timer output one.
// R6: Pin 4: gpio, RC resistor/capacitor sensor; upper two codes prohibited.
// R7: Pin 5: gpio, RC oscillation monitor; upper two codes prohibited.
// R8: Prohibited code in output mode ignores data; float or hold low.
// R9: Each pin chooses output or input from its direction bit.
// R10: Output drive: high-impedance, P-channel, N-channel open drain or CMOS.
// R11: Input mode: high-impedance, pull-down or pull-up per pin.
// R12: After reset every pin is a high-impedance output.
// R13: Output mode drives each pin from its data register bit.
// R14: Input mode data read returns the present pin level.
// R15: Code zero also serves analog inputs and external interrupts.
// R16: Software sets analog pins hi-z output, interrupt pins input.
// R17: Software sets RC pins hi-z input and RC codes first.
// R18: Config code 00 hi-z, 01 P-ch/pull-down, 10 N-ch/pull-up, 11 CMOS.
// R19: Direction bit zero is output and reset value; one is input.
// R20: Peripheral output reaches a pin only when selected; levels always.
module pfs_port0_fsel
  import pfs_pkg::*;
#(
  parameter int ADDR_W = 18
) (
  input  wire logic              ref_clk_in,
  input  wire logic              rst_in,
  input  wire logic [ADDR_W-1:0] avs_address_in,
  input  wire logic              avs_read_in,
  input  wire logic              avs_write_in,
  input  wire logic [3:0]        avs_byteenable_in,
  input  wire logic [31:0]       avs_writedata_in,
  output logic      [31:0]       avs_readdata_out,
  output logic                   avs_waitrequest_out,
  input  wire logic [5:0]        pin_in,
  output logic      [5:0]        pin_out,
  output logic      [5:0]        pin_oe_out,
  output logic      [5:0]        pin_pull_up_out,
  output logic      [5:0]        pin_pull_down_out,
  output logic      [5:0]        pin_level_out,
  input  wire logic              sync_serial_data_out_in,
  input  wire logic              sync_serial_clock_in,
  input  wire logic              sync_serial_clock_oe_in,
  input  wire logic              uart_transmit_out_in,
  input  wire logic              timer_output_zero_in,
  input  wire logic              timer_output_one_in,
  input  wire logic [5:0]        rc_drive_in,
  input  wire logic [5:0]        rc_drive_oe_in
);

  pfs_bus_e    state_r, state_nxt;
  logic [7:0]  data_r, data_nxt;
  logic [7:0]  dir_r, dir_nxt;
  logic [15:0] con_r, con_nxt;
  logic [15:0] mode_r, mode_nxt;
  logic [31:0] rdata_r, rdata_nxt;
  logic [5:0]  level_r, level_nxt;
  logic        req;
  logic        commit_wr;
  logic [5:0]  alt2_val, alt2_en, alt3_val, alt3_en;
  logic [15:0] rd_mux;

  // Pins on which codes 10 and 11 are prohibited, one bit per pin
  localparam logic [5:0] ALT2_BAD = `PFS_ALT2_BAD;
  localparam logic [5:0] ALT3_BAD = `PFS_ALT3_BAD;

  // Merge written byte lanes into a 16-bit register
  function automatic logic [15:0] merge16(input logic [15:0] old,
                                          input logic [15:0] wd,
                                          input logic [1:0]  be);
    logic [15:0] res;
    res = old;
    if (be[0]) begin
      res[7:0] = wd[7:0];
    end
    if (be[1]) begin
      res[15:8] = wd[15:8];
    end
    return res;
  endfunction : merge16

  // Output source of one pin from its select code
  function automatic pfs_src_s route_pin(input int         p,
                                         input logic [1:0] code,
                                         input logic [7:0] dat);
    pfs_src_s s;
    s = '{drive: 1'h0, val: 1'h0, prohib: 1'h0};
    case (code)
      `PFS_CODE_GPIO: begin
        s.drive = 1'h1;  // see R13
        s.val   = dat[p];
      end
      `PFS_CODE_RC: begin
        s.drive = rc_drive_oe_in[p];  // see R20
        s.val   = rc_drive_in[p];
      end
      `PFS_CODE_ALT2: begin
        s.prohib = ALT2_BAD[p];  // see R5
        s.drive  = alt2_en[p];  // see R20
        s.val    = alt2_val[p];
      end
      `PFS_CODE_ALT3: begin
        s.prohib = ALT3_BAD[p];  // see R6
        s.drive  = alt3_en[p];  // see R20
        s.val    = alt3_val[p];
      end
      default: begin
        s.drive = 1'h0;
      end
    endcase
    return s;
  endfunction : route_pin

  // Peripheral outputs per pin for codes 10 and 11
  // Pin 0 serial data out, pin 2 serial clock; see R2 see R4
  assign alt2_en  = {3'h0, sync_serial_clock_oe_in, 1'h0, 1'h1};
  assign alt2_val = {3'h0, sync_serial_clock_in, 1'h0,
                     sync_serial_data_out_in};
  // Pin 1 UART transmit, pins 2 and 3 timer outputs; see R3 see R5
  assign alt3_en  = 6'h0E;
  assign alt3_val = {2'h0, timer_output_one_in, timer_output_zero_in,
                     uart_transmit_out_in, 1'h0};

  // Bus request decode and answer
  assign req                 = avs_read_in || avs_write_in;
  assign commit_wr           = (state_r == BUS_ACK) && avs_write_in;
  assign avs_waitrequest_out = req && (state_r != BUS_ACK);
  assign avs_readdata_out    = rdata_r;
  assign pin_level_out       = level_r;

  // Read data mux; data reads pin level in input mode
  always_comb begin
    rd_mux = 16'h0000;
    if (avs_address_in == `PFS_BADDR(`PFS_IDX_DATA)) begin
      rd_mux = {8'h00, data_r[7:6],
                (dir_r[5:0] & pin_in) | (~dir_r[5:0] & data_r[5:0])};
    end else if (avs_address_in == `PFS_BADDR(`PFS_IDX_DIR)) begin
      rd_mux = {8'h00, dir_r};
    end else if (avs_address_in == `PFS_BADDR(`PFS_IDX_CON)) begin
      rd_mux = con_r;
    end else if (avs_address_in == `PFS_BADDR(`PFS_IDX_MODE)) begin
      rd_mux = mode_r;
    end
  end

  // Next state of bus slave, registers and pin levels
  always_comb begin
    state_nxt = state_r;
    data_nxt  = data_r;
    dir_nxt   = dir_r;
    con_nxt   = con_r;
    mode_nxt  = mode_r;
    rdata_nxt = rdata_r;
    level_nxt = pin_in;  // see R15 see R20
    case (state_r)
      BUS_IDLE: begin
        if (req) begin
          state_nxt = BUS_ACK;
          rdata_nxt = {16'h0000, rd_mux};  // see R14
        end
      end
      BUS_ACK: begin
        state_nxt = BUS_IDLE;
      end
      default: begin
        state_nxt = BUS_IDLE;
      end
    endcase
    if (commit_wr) begin
      if (avs_address_in == `PFS_BADDR(`PFS_IDX_DATA) &&
          avs_byteenable_in[0]) begin
        data_nxt = avs_writedata_in[7:0];
      end
      if (avs_address_in == `PFS_BADDR(`PFS_IDX_DIR) &&
          avs_byteenable_in[0]) begin
        dir_nxt = avs_writedata_in[7:0];  // see R19
      end
      if (avs_address_in == `PFS_BADDR(`PFS_IDX_CON)) begin
        con_nxt = merge16(con_r, avs_writedata_in[15:0],
                          avs_byteenable_in[1:0]);  // see R18
      end
      if (avs_address_in == `PFS_BADDR(`PFS_IDX_MODE)) begin
        mode_nxt = merge16(mode_r, avs_writedata_in[15:0],
                           avs_byteenable_in[1:0]);  // see R1
      end
    end
  end

  // Register state; reset gives output mode, high-impedance drive
  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      state_r <= BUS_IDLE;
      data_r  <= `PFS_RST_DATA;
      dir_r   <= `PFS_RST_DIR;  // see R12 see R19
      con_r   <= `PFS_RST_CON;  // see R12
      mode_r  <= `PFS_RST_MODE;  // see R1
      rdata_r <= 32'h00000000;
      level_r <= 6'h00;
    end else begin
      state_r <= state_nxt;
      data_r  <= data_nxt;
      dir_r   <= dir_nxt;
      con_r   <= con_nxt;
      mode_r  <= mode_nxt;
      rdata_r <= rdata_nxt;
      level_r <= level_nxt;
    end
  end

  // One pad cell per pin, fed through the carrier
  for (genvar g = 0; g < 6; g++) begin : g_pin
    pfs_pad_if pad_if ();

    assign pad_if.dir = dir_r[g];  // see R9
    assign pad_if.cfg = pfs_drive_e'({con_r[g + `PFS_HI_LSB], con_r[g]});
    // Procedural, so peripheral inputs read inside the function wake it
    always_comb begin
      pad_if.src = route_pin(g, {mode_r[g + `PFS_HI_LSB],
                                 mode_r[g]}, data_r);  // see R7
    end

    pfs_pad_cell u_pad (
      .ref_clk_in (ref_clk_in),
      .rst_in     (rst_in),
      .pad        (pad_if.pad)
    );

    assign pin_out[g]           = pad_if.pin_out;
    assign pin_oe_out[g]        = pad_if.pin_oe;
    assign pin_pull_up_out[g]   = pad_if.pull_up;
    assign pin_pull_down_out[g] = pad_if.pull_down;
  end

  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (rst_in);

  sequence s_req_wait;
    req && avs_waitrequest_out;
  endsequence

  sequence s_req_held;
    req;
  endsequence

  property p_answer_next;
    s_req_wait ##1 s_req_held |-> !avs_waitrequest_out;
  endproperty
  a_answer_next: assert property (p_answer_next)
    else $error("no answer one cycle after request");

  property p_mode_word;
    commit_wr && avs_address_in == `PFS_BADDR(`PFS_IDX_MODE)
      && avs_byteenable_in[1:0] == 2'h3
      |=> mode_r == $past(avs_writedata_in[15:0]);
  endproperty
  a_mode_word: assert property (p_mode_word)  // see R1
    else $error("select word write lost");

  property p_mode_low_byte;
    commit_wr && avs_address_in == `PFS_BADDR(`PFS_IDX_MODE)
      && avs_byteenable_in[1:0] == 2'h1
      |=> mode_r[15:8] == $past(mode_r[15:8])
       && mode_r[7:0] == $past(avs_writedata_in[7:0]);
  endproperty
  a_mode_low_byte: assert property (p_mode_low_byte)  // see R1
    else $error("select low byte write wrong");

  property p_data_read;
    state_r == BUS_IDLE && avs_read_in
      && avs_address_in == `PFS_BADDR(`PFS_IDX_DATA)
      |=> avs_readdata_out[5:0] == $past((dir_r[5:0] & pin_in)
                                       | (~dir_r[5:0] & data_r[5:0]));
  endproperty
  a_data_read: assert property (p_data_read)  // see R14
    else $error("data read does not show pin level");

  property p_level_route;
    !$past(rst_in) |-> pin_level_out == $past(pin_in);
  endproperty
  a_level_route: assert property (p_level_route)  // see R20
    else $error("pin level not routed");

  property p_reset_state;
    $fell(rst_in) |-> mode_r == 16'h0000 && dir_r == 8'h00
                   && con_r == 16'h0000 && pin_oe_out == 6'h00;
  endproperty
  a_reset_state: assert property (p_reset_state)  // see R12
    else $error("reset state not high-impedance output");

  // Serial data input function on pin 1 never drives the pin
  property p_serial_in_quiet;
    !dir_r[1] && mode_r[9] && !mode_r[1] |=> !pin_oe_out[1];
  endproperty
  a_serial_in_quiet: assert property (p_serial_in_quiet)  // see R3
    else $error("serial data input pin driven");

  // UART receive function on pin 0 never drives the pin
  property p_rx_quiet;
    !dir_r[0] && mode_r[8] && mode_r[0] |=> !pin_oe_out[0];
  endproperty
  a_rx_quiet: assert property (p_rx_quiet)  // see R2
    else $error("UART receive pin driven");

endmodule : pfs_port0_fsel
`default_nettype wire

/* bench/pfs_pin_model.sv */
// Far-side model: package pins with outside drivers and pulls
`timescale 1ns/1ps
`default_nettype none
module pfs_pin_model (
  input  wire logic       ref_clk_in,
  input  wire logic [5:0] oe_in,
  input  wire logic [5:0] out_in,
  input  wire logic [5:0] pull_up_in,
  input  wire logic [5:0] pull_down_in,
  input  wire logic [5:0] ext_en_in,
  input  wire logic [5:0] ext_val_in,
  output logic      [5:0] level_out
);
  logic [5:0] last_r = 6'h00;

  // Wire level: pad drive, outside drive, pull, else drifting
  always_comb begin
    for (int i = 0; i < 6; i++) begin
      if (oe_in[i]) level_out[i] = out_in[i];
      else if (ext_en_in[i]) level_out[i] = ext_val_in[i];
      else if (pull_up_in[i]) level_out[i] = 1'b1;
      else if (pull_down_in[i]) level_out[i] = 1'b0;
      else level_out[i] = ~last_r[i]; // Floating pin never holds
    end
  end

  // Remember the last level so a floating pin keeps changing
  always_ff @(posedge ref_clk_in) begin
    last_r <= level_out;
  end
endmodule : pfs_pin_model
`default_nettype wire

/* bench/pfs_port0_fsel_tb.sv */
// Self-checking testbench of the port 0 function select block
`timescale 1ns/1ps
`default_nettype none
`include "pfs_port0_regs.svh"
module pfs_port0_fsel_tb;
  import pfs_pkg::*;

  typedef struct packed {
    logic [5:0]  dir;
    logic [15:0] con;
    logic [15:0] mode;
    logic [7:0]  data;
    logic [5:0]  per;
    logic [5:0]  rcd;
    logic [5:0]  rco;
    logic [5:0]  e_oe;
    logic [5:0]  e_out;
    logic [5:0]  e_pu;
    logic [5:0]  e_pd;
  } pfs_row_s;

  localparam logic [17:0] A_DATA = `PFS_BADDR(`PFS_IDX_DATA);
  localparam logic [17:0] A_DIR  = `PFS_BADDR(`PFS_IDX_DIR);
  localparam logic [17:0] A_CON  = `PFS_BADDR(`PFS_IDX_CON);
  localparam logic [17:0] A_MODE = `PFS_BADDR(`PFS_IDX_MODE);

  logic        clk = 1'b0;
  logic        rst;
  logic [17:0] av_addr;
  logic        av_rd;
  logic        av_wr;
  logic [3:0]  av_be;
  logic [31:0] av_wd;
  logic [31:0] av_rdata;
  logic        av_wait;
  logic [5:0]  pin_lvl;
  logic [5:0]  pout;
  logic [5:0]  poe;
  logic [5:0]  pu;
  logic [5:0]  pd;
  logic [5:0]  plevel;
  logic [5:0]  per;
  logic [5:0]  rcd;
  logic [5:0]  rco;
  logic [5:0]  ext_en;
  logic [5:0]  ext_val;
  logic [31:0] rdv;
  int          fails;
  int          total_checks;
  int          cycles;

  // Per-pin settings and the pad states they must give
  pfs_row_s rows [14] = '{
    '{6'h00,16'h3F3F,16'h0000,8'h2A,6'h3F,6'h00,6'h3F,6'h3F,6'h2A,6'h0,6'h0},
    '{6'h00,16'h003F,16'h0000,8'h2A,6'h00,6'h00,6'h00,6'h2A,6'h2A,6'h0,6'h0},
    '{6'h00,16'h3F00,16'h0000,8'h2A,6'h00,6'h00,6'h00,6'h15,6'h00,6'h0,6'h0},
    '{6'h00,16'h0000,16'h0000,8'h3F,6'h00,6'h00,6'h00,6'h00,6'h00,6'h0,6'h0},
    '{6'h3F,16'h003F,16'h0000,8'h00,6'h00,6'h00,6'h00,6'h00,6'h00,6'h0,6'h3F},
    '{6'h3F,16'h3F00,16'h0000,8'h00,6'h00,6'h00,6'h00,6'h00,6'h00,6'h3F,6'h0},
    '{6'h3F,16'h3F3F,16'h0000,8'h00,6'h00,6'h00,6'h00,6'h00,6'h00,6'h0,6'h0},
    '{6'h00,16'h3F3F,16'h3F00,8'h3F,6'h07,6'h00,6'h00,6'h3D,6'h05,6'h0,6'h0},
    '{6'h00,16'h3F3F,16'h3F3F,8'h3F,6'h28,6'h00,6'h00,6'h3E,6'h0A,6'h0,6'h0},
    '{6'h00,16'h003F,16'h3F3F,8'h3F,6'h28,6'h00,6'h00,6'h0A,6'h0A,6'h0,6'h0},
    '{6'h00,16'h3F00,16'h3F00,8'h3F,6'h08,6'h00,6'h00,6'h39,6'h00,6'h0,6'h0},
    '{6'h00,16'h3F3F,16'h003F,8'h00,6'h00,6'h15,6'h0F,6'h0F,6'h05,6'h0,6'h0},
    '{6'h3F,16'h3F00,16'h3F3F,8'h00,6'h3F,6'h3F,6'h3F,6'h00,6'h00,6'h3F,6'h0},
    '{6'h00,16'h3F3F,16'h3F00,8'h00,6'h02,6'h00,6'h00,6'h39,6'h00,6'h0,6'h0}
  };

  pfs_port0_fsel #(.ADDR_W(18)) i_pfs_port0_fsel (
    .ref_clk_in              (clk),
    .rst_in                  (rst),
    .avs_address_in          (av_addr),
    .avs_read_in             (av_rd),
    .avs_write_in            (av_wr),
    .avs_byteenable_in       (av_be),
    .avs_writedata_in        (av_wd),
    .avs_readdata_out        (av_rdata),
    .avs_waitrequest_out     (av_wait),
    .pin_in                  (pin_lvl),
    .pin_out                 (pout),
    .pin_oe_out              (poe),
    .pin_pull_up_out         (pu),
    .pin_pull_down_out       (pd),
    .pin_level_out           (plevel),
    .sync_serial_data_out_in (per[0]),
    .sync_serial_clock_in    (per[1]),
    .sync_serial_clock_oe_in (per[2]),
    .uart_transmit_out_in    (per[3]),
    .timer_output_zero_in    (per[4]),
    .timer_output_one_in     (per[5]),
    .rc_drive_in             (rcd),
    .rc_drive_oe_in          (rco)
  );

  pfs_pin_model i_pfs_pin_model (
    .ref_clk_in   (clk),
    .oe_in        (poe),
    .out_in       (pout),
    .pull_up_in   (pu),
    .pull_down_in (pd),
    .ext_en_in    (ext_en),
    .ext_val_in   (ext_val),
    .level_out    (pin_lvl)
  );

  // Clock and hang guard
  always #10 clk = ~clk;
  always @(posedge clk) begin
    cycles++;
    if (cycles == 5000) begin
      fails++;
      finish_test();
    end
  end

  task automatic finish_test();
    $display("checks %0d, mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : finish_test

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      fails++;
      $display("mismatch at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask : check

  // One bus cycle, held until waitrequest is seen low at a rising edge
  task automatic bus(input logic wr, input logic [17:0] a,
                     input logic [15:0] wd, input logic [3:0] be);
    @(posedge clk);
    av_addr <= a;
    av_wd <= {16'h0000, wd};
    av_be <= be;
    av_wr <= wr;
    av_rd <= ~wr;
    @(posedge clk);
    while (av_wait !== 1'b0) begin
      @(posedge clk);
    end
    rdv = av_rdata;
    av_wr <= 1'b0;
    av_rd <= 1'b0;
  endtask : bus

  // Compare pad outputs after the registers have settled
  task automatic pads(input logic [5:0] oe, input logic [5:0] o,
                      input logic [5:0] u, input logic [5:0] d);
    repeat (3) @(posedge clk);
    check(poe, oe);
    check(pout & poe, o);
    check(pu, u);
    check(pd, d);
  endtask : pads

  initial begin
    rst = 1'b1;
    {av_rd, av_wr, av_be, av_wd, av_addr} = '0;
    {per, rcd, rco, ext_en, ext_val} = '0;
    fails = 0;
    total_checks = 0;
    cycles = 0;
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    // Table of pin settings
    foreach (rows[i]) begin
      per <= rows[i].per;
      rcd <= rows[i].rcd;
      rco <= rows[i].rco;
      bus(1'b1, A_DIR, {10'h000, rows[i].dir}, 4'h1);
      bus(1'b1, A_CON, rows[i].con, 4'h3);
      bus(1'b1, A_MODE, rows[i].mode, 4'h3);
      bus(1'b1, A_DATA, {8'h00, rows[i].data}, 4'h1);
      pads(rows[i].e_oe, rows[i].e_out, rows[i].e_pu, rows[i].e_pd);
    end
    // Byte lanes of the select register, unwritten byte kept, all 16 bits writable
    bus(1'b1, A_MODE, 16'hABCD, 4'h1);
    bus(1'b0, A_MODE, 16'h0000, 4'hF);
    check(rdv, 32'h00003FCD);
    bus(1'b1, A_MODE, 16'h12FF, 4'h2);
    bus(1'b0, A_MODE, 16'h0000, 4'hF);
    check(rdv, 32'h000012CD);
    bus(1'b1, A_MODE, 16'hFFFF, 4'h3);
    bus(1'b0, A_MODE, 16'h0000, 4'hF);
    check(rdv, 32'h0000FFFF);
    // Output mode reads back the written data
    bus(1'b1, A_DIR, 16'h0000, 4'h1);
    bus(1'b1, A_DATA, 16'h00C5, 4'h1);
    bus(1'b0, A_DATA, 16'h0000, 4'hF);
    check(rdv, 32'h000000C5);
    // Hi-z input first, then converter codes; outside drives the pins
    bus(1'b1, A_CON, 16'h0000, 4'h3);
    bus(1'b1, A_DIR, 16'h003F, 4'h1);
    bus(1'b1, A_MODE, 16'h003F, 4'h3);
    ext_val <= 6'h29;
    ext_en <= 6'h3F;
    pads(6'h00, 6'h00, 6'h00, 6'h00);
    check(plevel, 6'h29);
    bus(1'b0, A_DATA, 16'h0000, 4'hF);
    check(rdv[5:0], 6'h29);
    // Unmapped place: reads zero, write lost
    bus(1'b1, 18'h00000, 16'hFFFF, 4'h3);
    bus(1'b0, 18'h00000, 16'h0000, 4'hF);
    check(rdv, 32'h00000000);
    bus(1'b0, A_DIR, 16'h0000, 4'hF);
    check(rdv, 32'h0000003F);
    // Converter drives every pin as CMOS output before the reset
    rco <= 6'h3F;
    rcd <= 6'h2A;
    bus(1'b1, A_CON, 16'h3F3F, 4'h3);
    bus(1'b1, A_DIR, 16'h0000, 4'h1);
    pads(6'h3F, 6'h2A, 6'h00, 6'h00);
    // Reset in mid-run returns every pin to hi-z output
    @(posedge clk);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    check(poe, 6'h00);
    check(pu | pd, 6'h00);
    rst <= 1'b0;
    bus(1'b0, A_MODE, 16'h0000, 4'hF);
    check(rdv, 32'h00000000);
    bus(1'b0, A_DIR, 16'h0000, 4'hF);
    check(rdv, 32'h00000000);
    bus(1'b0, A_CON, 16'h0000, 4'hF);
    check(rdv, 32'h00000000);
    pads(6'h00, 6'h00, 6'h00, 6'h00);
    finish_test();
  end
endmodule : pfs_port0_fsel_tb
`default_nettype wire
